//--- verilog/aif_pkg.sv
// constants, layouts and carrier types for the antenna interface fault and dma decode block
package aif_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb register offsets (byte addresses)
  localparam logic [7:0] OFS_CFG_FAULT = 8'h00;
  localparam logic [7:0] OFS_DRD_FAULT = 8'h04;
  localparam logic [7:0] OFS_DWR_FAULT = 8'h08;
  localparam logic [7:0] OFS_TX_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_CB_CFG    = 8'h10;
  localparam logic [7:0] OFS_RX_CFG    = 8'h14;
  localparam logic [7:0] OFS_LINK_STAT = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // config bus fault capture layout
  localparam int unsigned CFG_ADDR_LSB = 0;
  localparam int unsigned CFG_BE_LSB   = 16;
  localparam int unsigned CFG_ST_LSB   = 20;
  localparam int unsigned CFG_DIR_BIT  = 24;
  localparam logic [2:0]  ST_ADDR_FAULT = 3'h1;
  localparam logic [2:0]  ST_DATA_FAULT = 3'h4;
  localparam logic [3:0]  BE_FULL_WORD  = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // tx control layout and reset values
  localparam int unsigned TX_THR_LSB    = 0;
  localparam int unsigned TX_CPRI_BIT   = 8;
  localparam int unsigned TX_BYPASS_BIT = 9;
  localparam int unsigned TX_IRATE_LSB  = 12;
  localparam int unsigned TX_ORATE_LSB  = 14;
  localparam int unsigned TX_START_LSB  = 16;
  localparam logic [4:0]  TX_FULL_MAX   = 5'h1c;
  localparam logic [4:0]  TX_FULL_RST   = 5'h1c;
  localparam logic [31:0] TX_CTRL_RST   = 32'h0000_001c;
  localparam logic [31:0] CFG_RST       = 32'h0000_0000;
  localparam int unsigned TX_FILL_MIN   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // link status layout
  localparam int unsigned LS_ZERO_BIT  = 0;
  localparam int unsigned LS_LARGE_BIT = 1;
  localparam int unsigned LS_OVF_BIT   = 2;
  localparam int unsigned LS_RATE_BIT  = 3;
  localparam int unsigned LS_INP_LSB   = 4;
  localparam int unsigned LS_OUTP_LSB  = 12;

  ////////////////////////////////////////////////////////////////////////////
  // combiner buffering and fixed pipeline latencies (bus clocks)
  localparam logic [17:0] CD_MSG_BYTES   = 18'd19;
  localparam logic [17:0] CD_MSG_DEPTH   = 18'd5;
  localparam logic [17:0] CD_BUF_BYTES   = CD_MSG_BYTES * CD_MSG_DEPTH;
  localparam logic [4:0]  IN_PIPE_OBSAI  = 5'h01;
  localparam logic [4:0]  IN_PIPE_CPRI   = 5'h05;
  localparam logic [4:0]  OUT_PIPE_OBSAI = 5'h0a;
  localparam logic [4:0]  OUT_PIPE_CPRI  = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // dma address map: bits [31:23] for 8 MB windows, [31:24] for 16 MB ones
  localparam logic [8:0] DMA_ICS_BASE = 9'h140;
  localparam logic [8:0] DMA_OCS_BASE = 9'h144;
  localparam logic [7:0] DMA_IPF      = 8'ha4;
  localparam logic [7:0] DMA_OPF      = 8'ha5;
  localparam logic [7:0] DMA_IPR      = 8'ha6;
  localparam logic [7:0] DMA_OPR      = 8'ha7;
  localparam logic [7:0] DMA_CMPL     = 8'ha8;
  localparam logic [7:0] DMA_TRACE    = 8'ha9;

  // one-hot region bits
  localparam int unsigned RG_IPF   = 6;
  localparam int unsigned RG_OPF   = 7;
  localparam int unsigned RG_IPR   = 8;
  localparam int unsigned RG_OPR   = 9;
  localparam int unsigned RG_CMPL  = 10;
  localparam int unsigned RG_TRACE = 11;
  localparam logic [11:0] RD_ALLOW = 12'hb7f;
  localparam logic [11:0] WR_ALLOW = 12'hfbf;
  localparam logic [11:0] RG_NONE  = 12'h000;

  typedef logic [11:0] aif_region_t;

  // dma request carrier
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } aif_dma_req_s;

  // apb answer sequencing
  typedef enum logic [2:0] {
    APB_IDLE = 3'b001,
    APB_ACC  = 3'b010,
    APB_DONE = 3'b100
  } aif_apb_state_e;

endpackage

//--- verilog/aif_dma_decode.sv
// dma port address decoder: region select and direction permission
module aif_dma_decode (
  // request
  input  aif_pkg::aif_dma_req_s req,
  // decode result
  output aif_pkg::aif_region_t  region,
  output logic                  allowed
);

  logic [2:0] ics_hit;
  logic [2:0] ocs_hit;

  ////////////////////////////////////////////////////////////////////////////
  // circuit switched windows, one per link pair
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_cs
    assign ics_hit[gi] = req.addr[31:23] == 9'(aif_pkg::DMA_ICS_BASE + 9'(gi));
    assign ocs_hit[gi] = req.addr[31:23] == 9'(aif_pkg::DMA_OCS_BASE + 9'(gi));
  end

  ////////////////////////////////////////////////////////////////////////////
  // 8 MB windows and 16 MB regions; gaps between windows decode to no region
  always_comb begin
    region = aif_pkg::RG_NONE;
    if (|ics_hit) begin
      region[2:0] = ics_hit;
    end else if (|ocs_hit) begin
      region[5:3] = ocs_hit;
    end else if (req.addr[31:24] == aif_pkg::DMA_IPF) begin
      region[aif_pkg::RG_IPF] = 1'b1;
    end else if (req.addr[31:24] == aif_pkg::DMA_OPF) begin
      region[aif_pkg::RG_OPF] = 1'b1;
    end else if (req.addr[31:24] == aif_pkg::DMA_IPR) begin
      region[aif_pkg::RG_IPR] = 1'b1;
    end else if (req.addr[31:24] == aif_pkg::DMA_OPR) begin
      region[aif_pkg::RG_OPR] = 1'b1;
    end else if (req.addr[31:24] == aif_pkg::DMA_CMPL) begin
      region[aif_pkg::RG_CMPL] = 1'b1;
    end else if (req.addr[31:24] == aif_pkg::DMA_TRACE) begin
      region[aif_pkg::RG_TRACE] = 1'b1;
    end
  end

  // reserved space or wrong direction is refused
  assign allowed = |(region & (req.write ? aif_pkg::WR_ALLOW : aif_pkg::RD_ALLOW));

endmodule

//--- verilog/aif_fault_dma_regs.sv
// bus fault capture, dma decode and transmit timing controls for the antenna interface
//
// Summary of operation
// - config bus error records word address 17:2, byte enables and status 001/100.
// - any write to the config fault register clears it entirely; here a partial-word write records a data fault instead.
// - dma read error records address 27:4 in bits 23:0, upper bits zero.
// - any write to the dma read fault register clears it; here partial-word writes fault instead, and a same-cycle capture wins.
// - dma write error records address 27:4, upper bits zero.
// - any write to the dma write fault register clears it; here partial-word writes fault instead, and a same-cycle capture wins.
// - three 8 MB inbound circuit RAM windows, read and write, per link pair.
// - three 8 MB outbound circuit RAM windows, read and write, per link pair.
// - 16 MB read-only inbound packet FIFO region pops on reads.
// - 16 MB write-only outbound packet FIFO region pushes on writes.
// - inbound and outbound packet RAMs each get a 16 MB read/write region.
// - write-only completion register region and read/write trace RAM region.
// - transmit FIFO full threshold is programmable, at most 28.
// - decombining buffers five 19-byte messages per output link.
// - a too-large transmit start offset overflows combiner FIFOs; detect it.
// - with combiner bypassed, input and output byte rates must match.
// - combining adds no delay when sync offsets and valid windows match.
// - pipeline latency: in 1 or 5, out 10 or 16 bus clocks.
//
// The implementer's own choices: the APB slave port and the register offsets.
module aif_fault_dma_regs (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [17:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // dma port
  input  wire aif_pkg::aif_dma_req_s  dma_req,
  output logic                        dma_ack,
  output logic                        dma_err,
  output aif_pkg::aif_region_t        dma_region,
  output logic                        dma_pop,
  output logic                        dma_push,
  // combiner status from link logic
  input  wire logic                   cd_fifo_ovf,
  // timing controls
  output logic [4:0]                  tx_fifo_full_threshold,
  output logic [4:0]                  in_pipe_delay,
  output logic [4:0]                  out_pipe_delay,
  output logic                        cd_zero_delay
);

  aif_pkg::aif_apb_state_e state;
  aif_pkg::aif_apb_state_e next_state;
  aif_pkg::aif_region_t    dec_region;
  logic                    dec_allowed;
  logic [31:0]             cfg_fault;
  logic [23:0]             drd_fault;
  logic [23:0]             dwr_fault;
  logic [31:0]             tx_ctrl;
  logic [31:0]             cb_cfg;
  logic [31:0]             rx_cfg;
  logic                    ovf_seen;
  logic [31:0]             rd_val;
  logic                    map_hit;
  logic                    data_fault;
  logic                    bus_err;
  logic                    commit;
  logic                    wr_commit;
  logic [7:0]              off;
  logic                    offset_too_large;
  logic                    rate_mismatch;
  logic [17:0]             cd_limit;
  logic [4:0]              thr_wr;

  assign off       = paddr[7:0];
  assign commit    = psel & penable & pready;
  assign wr_commit = commit & pwrite & ~pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // dma address decode
  aif_dma_decode u_decode (
    .req     (dma_req),
    .region  (dec_region),
    .allowed (dec_allowed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb answer sequencing: two wait states, then pready
  always_comb begin
    next_state = state;
    case (state)
      aif_pkg::APB_IDLE: if (psel & penable) next_state = aif_pkg::APB_ACC;
      aif_pkg::APB_ACC:  next_state = aif_pkg::APB_DONE;
      aif_pkg::APB_DONE: next_state = aif_pkg::APB_IDLE;
      default:           next_state = aif_pkg::APB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) state <= aif_pkg::APB_IDLE;
    else       state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux and error classification
  always_comb begin
    rd_val  = 32'h0000_0000;
    map_hit = 1'b1;
    if (paddr[17:8] != 10'h000 || paddr[1:0] != 2'h0) begin
      map_hit = 1'b0;
    end else if (off == aif_pkg::OFS_CFG_FAULT) begin
      rd_val = cfg_fault;
    end else if (off == aif_pkg::OFS_DRD_FAULT) begin
      rd_val = {8'h00, drd_fault};
    end else if (off == aif_pkg::OFS_DWR_FAULT) begin
      rd_val = {8'h00, dwr_fault};
    end else if (off == aif_pkg::OFS_TX_CTRL) begin
      rd_val = tx_ctrl;
    end else if (off == aif_pkg::OFS_CB_CFG) begin
      rd_val = cb_cfg;
    end else if (off == aif_pkg::OFS_RX_CFG) begin
      rd_val = rx_cfg;
    end else if (off == aif_pkg::OFS_LINK_STAT) begin
      rd_val = {15'h0000, out_pipe_delay, 3'h0, in_pipe_delay,
                rate_mismatch, ovf_seen, offset_too_large, cd_zero_delay};
    end else begin
      map_hit = 1'b0;
    end
  end

  // partial-word writes are data faults; registers are whole words only
  assign data_fault = map_hit & pwrite & (pstrb != aif_pkg::BE_FULL_WORD);
  assign bus_err    = ~map_hit | data_fault;

  ////////////////////////////////////////////////////////////////////////////
  // apb outputs, registered so that they come straight from flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= (state == aif_pkg::APB_ACC);
      if (state == aif_pkg::APB_ACC) begin
        pslverr <= bus_err;
        prdata  <= (pwrite | bus_err) ? 32'h0000_0000 : rd_val;
      end else if (commit) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // config bus fault capture; a new fault wins over a clearing write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_fault <= aif_pkg::CFG_RST;
    end else if (commit & pslverr) begin
      cfg_fault <= {7'h00, ~pwrite, 1'b0,
                    (data_fault ? aif_pkg::ST_DATA_FAULT : aif_pkg::ST_ADDR_FAULT),
                    pstrb, paddr[17:2]};
    end else if (wr_commit && off == aif_pkg::OFS_CFG_FAULT) begin
      cfg_fault <= aif_pkg::CFG_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma read and write fault capture; capture wins over clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drd_fault <= 24'h00_0000;
    end else if (dma_req.valid & ~dma_req.write & ~dec_allowed) begin
      drd_fault <= dma_req.addr[27:4];
    end else if (wr_commit && off == aif_pkg::OFS_DRD_FAULT) begin
      drd_fault <= 24'h00_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dwr_fault <= 24'h00_0000;
    end else if (dma_req.valid & dma_req.write & ~dec_allowed) begin
      dwr_fault <= dma_req.addr[27:4];
    end else if (wr_commit && off == aif_pkg::OFS_DWR_FAULT) begin
      dwr_fault <= 24'h00_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma answer: one cycle after the request, single-beat
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dma_ack    <= 1'b0;
      dma_err    <= 1'b0;
      dma_region <= aif_pkg::RG_NONE;
      dma_pop    <= 1'b0;
      dma_push   <= 1'b0;
    end else begin
      dma_ack    <= dma_req.valid & dec_allowed;
      dma_err    <= dma_req.valid & ~dec_allowed;
      dma_region <= (dma_req.valid & dec_allowed) ? dec_region : aif_pkg::RG_NONE;
      dma_pop    <= dma_req.valid & ~dma_req.write & dec_region[aif_pkg::RG_IPF];
      dma_push   <= dma_req.valid & dma_req.write & dec_region[aif_pkg::RG_OPF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software controls; threshold above the ceiling saturates
  assign thr_wr = (pwdata[4:0] > aif_pkg::TX_FULL_MAX) ? aif_pkg::TX_FULL_MAX : pwdata[4:0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_ctrl <= aif_pkg::TX_CTRL_RST;
      cb_cfg  <= aif_pkg::CFG_RST;
      rx_cfg  <= aif_pkg::CFG_RST;
    end else if (wr_commit) begin
      if (off == aif_pkg::OFS_TX_CTRL) begin
        tx_ctrl <= {pwdata[31:16], pwdata[15:12], 2'h0, pwdata[9:8], 3'h0, thr_wr};
      end else if (off == aif_pkg::OFS_CB_CFG) begin
        cb_cfg <= pwdata;
      end else if (off == aif_pkg::OFS_RX_CFG) begin
        rx_cfg <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // combiner overflow prediction: start offset beyond frame edge plus five messages
  assign cd_limit = 18'(rx_cfg[15:0]) + 18'(rx_cfg[31:16]) + aif_pkg::CD_BUF_BYTES;
  assign offset_too_large = 18'(tx_ctrl[31:16]) > cd_limit;
  // bypass with mismatched byte rates cannot be served
  assign rate_mismatch = tx_ctrl[aif_pkg::TX_BYPASS_BIT] &
                         (tx_ctrl[13:12] != tx_ctrl[15:14]);

  // sticky overflow; hardware set beats software clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ovf_seen <= 1'b0;
    end else if (cd_fifo_ovf | offset_too_large) begin
      ovf_seen <= 1'b1;
    end else if (wr_commit && off == aif_pkg::OFS_LINK_STAT && pwdata[aif_pkg::LS_OVF_BIT]) begin
      ovf_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing outputs seen by the link datapath
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_fifo_full_threshold <= aif_pkg::TX_FULL_RST;
      in_pipe_delay          <= aif_pkg::IN_PIPE_OBSAI;
      out_pipe_delay         <= aif_pkg::OUT_PIPE_OBSAI;
      cd_zero_delay          <= 1'b0;
    end else begin
      tx_fifo_full_threshold <= tx_ctrl[4:0];
      in_pipe_delay  <= tx_ctrl[aif_pkg::TX_CPRI_BIT] ? aif_pkg::IN_PIPE_CPRI : aif_pkg::IN_PIPE_OBSAI;
      out_pipe_delay <= tx_ctrl[aif_pkg::TX_CPRI_BIT] ? aif_pkg::OUT_PIPE_CPRI : aif_pkg::OUT_PIPE_OBSAI;
      cd_zero_delay  <= (cb_cfg[15:0] == rx_cfg[15:0]) && (cb_cfg[31:16] == rx_cfg[31:16]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb_chk @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_acc_start;
    psel && penable && !pready && state == aif_pkg::APB_IDLE;
  endsequence

  sequence s_answer;
    !pready ##1 pready;
  endsequence

  apb_answer_time_a: assert property (s_acc_start |=> s_answer)
    else $error("apb answer not two cycles after access start");

  cfg_addr_fault_a: assert property (commit && pslverr && !$past(data_fault) |=>
    cfg_fault[22:20] == aif_pkg::ST_ADDR_FAULT && cfg_fault[15:0] == $past(paddr[17:2]))
    else $error("config address fault not captured");

  cfg_dir_bit_a: assert property (commit && pslverr |=> cfg_fault[24] == !$past(pwrite))
    else $error("config fault direction wrong");

  cfg_clear_a: assert property (wr_commit && off == aif_pkg::OFS_CFG_FAULT |=> cfg_fault == 32'h0000_0000)
    else $error("config fault not cleared by write");

  drd_capture_a: assert property (dma_req.valid && !dma_req.write && !dec_allowed |=>
    drd_fault == $past(dma_req.addr[27:4]) && dma_err)
    else $error("dma read fault not captured");

  drd_clear_a: assert property (wr_commit && off == aif_pkg::OFS_DRD_FAULT &&
    !(dma_req.valid && !dma_req.write && !dec_allowed) |=> drd_fault == 24'h00_0000)
    else $error("dma read fault not cleared");

  dwr_capture_a: assert property (dma_req.valid && dma_req.write && !dec_allowed |=>
    dwr_fault == $past(dma_req.addr[27:4]) && dma_err)
    else $error("dma write fault not captured");

  dwr_clear_a: assert property (wr_commit && off == aif_pkg::OFS_DWR_FAULT &&
    !(dma_req.valid && dma_req.write && !dec_allowed) |=> dwr_fault == 24'h00_0000)
    else $error("dma write fault not cleared");

  ics_window_a: assert property (dma_req.valid && dma_req.addr[31:23] == 9'h141 |=>
    dma_ack && dma_region == 12'h002)
    else $error("inbound circuit window two not decoded");

  ipf_read_only_a: assert property (dma_req.valid && dma_req.write && dma_req.addr[31:24] == 8'ha4 |=>
    dma_err && !dma_ack && !dma_pop)
    else $error("write to read-only fifo region accepted");

  opf_push_a: assert property (dma_req.valid && dma_req.write && dma_req.addr[31:24] == 8'ha5 |=>
    dma_push && dma_ack)
    else $error("outbound fifo write did not push");

  thr_ceiling_a: assert property (tx_fifo_full_threshold <= 5'h1c)
    else $error("tx fifo threshold above ceiling");

  pipe_latency_a: assert property (tx_ctrl[aif_pkg::TX_CPRI_BIT] |=>
    in_pipe_delay == 5'h05 && out_pipe_delay == 5'h10)
    else $error("cpri pipeline latency wrong");

endmodule

//--- dv/aif_dma_master.sv
// dma bus master model: one request cycle per launch from the bench
module aif_dma_master (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // launch from bench
  input  wire logic             go,
  input  wire logic             wr,
  input  wire logic [31:0]      ad,
  // dma request
  output aif_pkg::aif_dma_req_s dma_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle cycles scramble the address so a stale request never looks valid by luck
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dma_req <= '0;
    end else if (go) begin
      dma_req <= '{valid: 1'b1, write: wr, addr: ad};
    end else begin
      dma_req <= '{valid: 1'b0, write: ~dma_req.write, addr: ~dma_req.addr};
    end
  end
endmodule

//--- dv/tb_antenna_if_bus_fault_and_dma_decode.sv
// self-checking bench for fault capture, dma decode and timing controls
module tb_antenna_if_bus_fault_and_dma_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk, rstn, psel, penable, pwrite, pready, pslverr, cd_fifo_ovf;
  logic                  go, wr, dma_ack, dma_err, dma_pop, dma_push, cd_zero_delay, er;
  logic [17:0]           paddr;
  logic [31:0]           pwdata, prdata, ad, rd, exp_rf, exp_wf;
  logic [3:0]            pstrb;
  logic [4:0]            thr, in_pd, out_pd;
  aif_pkg::aif_dma_req_s dma_req;
  aif_pkg::aif_region_t  dma_region;
  int                    bad_count, cmp_count;
  logic [31:0] ta[18] = '{32'ha000_0000, 32'ha080_0010, 32'ha100_0000, 32'ha180_0000, 32'ha200_0000,
    32'ha280_0000, 32'ha37f_fff0, 32'ha380_0000, 32'ha400_0000, 32'ha400_0100, 32'ha500_0010,
    32'ha500_0000, 32'ha600_0000, 32'ha700_0000, 32'ha800_0000, 32'ha800_0000, 32'ha900_0000,
    32'haa12_3450};
  logic tw[18] = '{0, 1, 0, 0, 1, 0, 1, 1, 0, 1, 1, 0, 0, 1, 1, 0, 0, 0};
  int   tr[18] = '{0, 1, 2, -1, 3, 4, 5, -1, 6, -1, 7, -1, 8, 9, 10, -1, 11, -1};

  aif_dma_master mdl_u (.core_clk(core_clk), .rstn(rstn), .go(go), .wr(wr), .ad(ad), .dma_req(dma_req));
  aif_fault_dma_regs dut_u (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_req(dma_req), .dma_ack(dma_ack), .dma_err(dma_err), .dma_region(dma_region),
    .dma_pop(dma_pop), .dma_push(dma_push), .cd_fifo_ovf(cd_fifo_ovf), .tx_fifo_full_threshold(thr),
    .in_pipe_delay(in_pd), .out_pipe_delay(out_pd), .cd_zero_delay(cd_zero_delay));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // apb transfer: request held until pready is seen, released on that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {10'h000, a};
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    // pready is seen high at this edge: take the answer and release here
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
  endtask

  // one dma request; a refusal updates the expected fault capture
  task automatic dma(input logic w, input logic [31:0] a, input int r);
    logic [11:0] rg;
    int          n;
    rg = (r < 0) ? 12'h000 : 12'h001 << r;
    @(posedge core_clk);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    @(posedge core_clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (dma_ack !== 1'b1 && dma_err !== 1'b1 && n < 8);
    if (dma_ack !== 1'b1 && dma_err !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    chk("dma_ack", {31'h0, r >= 0}, {31'h0, dma_ack});
    chk("dma_err", {31'h0, r < 0}, {31'h0, dma_err});
    chk("dma_region", {20'h0, rg}, {20'h0, dma_region});
    chk("dma_pop_push", {30'h0, rg[7], rg[6]}, {30'h0, dma_push, dma_pop});
    if (r < 0 && w) exp_wf = {8'h00, a[27:4]};
    if (r < 0 && !w) exp_rf = {8'h00, a[27:4]};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, cd_fifo_ovf, go, wr} = '0;
    {paddr, pwdata, pstrb, ad} = '0;
    {bad_count, cmp_count} = '0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("ports", {5'h1c, 5'h01, 5'h0a, 1'b1}, {thr, in_pd, out_pd, cd_zero_delay});
    rchk("tx_ctrl", aif_pkg::OFS_TX_CTRL, 32'h0000_001c);
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    rchk("cfg_fault", aif_pkg::OFS_CFG_FAULT, 32'h0110_0008);
    apb(1'b1, aif_pkg::OFS_CFG_FAULT, 32'h0000_1234, 4'hf);
    rchk("cfg_clear", aif_pkg::OFS_CFG_FAULT, 32'h0);
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h0000_0010, 4'h3);
    rchk("cfg_data", aif_pkg::OFS_CFG_FAULT, 32'h0043_0003);
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h0000_001f, 4'hf);
    rchk("thr_max", aif_pkg::OFS_TX_CTRL, 32'h0000_001c);
    // threshold 27 keeps the source at least four bytes ahead of the drain
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h0000_011b, 4'hf);
    repeat (2) @(posedge core_clk);
    #1;
    chk("cpri_ports", {5'h1b, 5'h05, 5'h10}, {thr, in_pd, out_pd});
    apb(1'b1, aif_pkg::OFS_CB_CFG, 32'h0016_0064, 4'hf);
    repeat (2) @(posedge core_clk);
    #1;
    chk("cd_zero_off", 32'h0, {31'h0, cd_zero_delay});
    apb(1'b1, aif_pkg::OFS_RX_CFG, 32'h0016_0064, 4'hf);
    repeat (2) @(posedge core_clk);
    #1;
    chk("cd_zero_on", 32'h1, {31'h0, cd_zero_delay});
    rchk("link_stat", aif_pkg::OFS_LINK_STAT, 32'h0001_0051);
    // start offset one past rx offset + window + five 19-byte messages, then at the limit
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h00da_011b, 4'hf);
    rchk("ovf_set", aif_pkg::OFS_LINK_STAT, 32'h0001_0057);
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h00d9_011b, 4'hf);
    rchk("ovf_sticky", aif_pkg::OFS_LINK_STAT, 32'h0001_0055);
    apb(1'b1, aif_pkg::OFS_LINK_STAT, 32'h0000_0004, 4'hf);
    rchk("ovf_clear", aif_pkg::OFS_LINK_STAT, 32'h0001_0051);
    @(posedge core_clk);
    cd_fifo_ovf <= 1'b1;
    @(posedge core_clk);
    cd_fifo_ovf <= 1'b0;
    rchk("ovf_input", aif_pkg::OFS_LINK_STAT, 32'h0001_0055);
    // bypass with input rate 1 against output rate 0, then matched rates
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h0000_131b, 4'hf);
    rchk("rate_bad", aif_pkg::OFS_LINK_STAT, 32'h0001_005d);
    apb(1'b1, aif_pkg::OFS_TX_CTRL, 32'h0000_531b, 4'hf);
    rchk("rate_ok", aif_pkg::OFS_LINK_STAT, 32'h0001_0055);
    for (int i = 0; i < 18; i++) dma(tw[i], ta[i], tr[i]);
    rchk("rd_fault", aif_pkg::OFS_DRD_FAULT, exp_rf);
    rchk("wr_fault", aif_pkg::OFS_DWR_FAULT, exp_wf);
    apb(1'b1, aif_pkg::OFS_DRD_FAULT, 32'hffff_ffff, 4'hf);
    apb(1'b1, aif_pkg::OFS_DWR_FAULT, 32'hffff_ffff, 4'hf);
    rchk("rd_clear", aif_pkg::OFS_DRD_FAULT, 32'h0);
    rchk("wr_clear", aif_pkg::OFS_DWR_FAULT, 32'h0);
    stop_test();
  end
endmodule
